// ==== common/bidc_defs.svh ====
`ifndef BIDC_DEFS_SVH
`define BIDC_DEFS_SVH

// Counter shape
`define BIDC_WIDTH        8

// Mode select codes
`define BIDC_MODE_HOLD    2'h0
`define BIDC_MODE_UP      2'h1
`define BIDC_MODE_DOWN    2'h2
`define BIDC_MODE_LOAD    2'h3

// Register offsets
`define BIDC_ADDR_W       4
`define BIDC_OFF_CTRL     4'h0
`define BIDC_OFF_COUNT    4'h4
`define BIDC_OFF_STATUS   4'h8
`define BIDC_OFF_MASK     4'hC

// Field positions
`define BIDC_CTRL_RUN     0
`define BIDC_COUNT_FLAG   8
`define BIDC_COUNT_OE     9
`define BIDC_EVT_TC       0
`define BIDC_EVT_LOAD     1
`define BIDC_EVT_W        2

// Reset values
`define BIDC_RST_CTRL     1'h1
`define BIDC_RST_COUNT    8'h00
`define BIDC_RST_STATUS   2'h0
`define BIDC_RST_MASK     2'h0
`define BIDC_RST_FLAG     1'h1
`define BIDC_RST_OE       1'h0

`endif

// ==== common/bidc_pkg.sv ====
package bidc_pkg;

  typedef enum logic [1:0] {
    OP_HOLD = 2'h0,
    OP_UP   = 2'h1,
    OP_DOWN = 2'h3,
    OP_LOAD = 2'h2
  } bidc_op_t;

endpackage

// ==== design/bidc_counter.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "bidc_defs.svh"

module bidc_counter #(
  parameter int         WIDTH     = `BIDC_WIDTH,
  parameter logic [1:0] MODE_HOLD = `BIDC_MODE_HOLD,
  parameter logic [1:0] MODE_UP   = `BIDC_MODE_UP,
  parameter logic [1:0] MODE_DOWN = `BIDC_MODE_DOWN,
  parameter logic [1:0] MODE_LOAD = `BIDC_MODE_LOAD
) (
  // Clock and reset
  input  wire logic                    clk_sys,
  input  wire logic                    rst,
  // Register port
  input  wire logic [`BIDC_ADDR_W-1:0] regAddr,
  input  wire logic [31:0]             regWrData,
  input  wire logic                    regWrite,
  input  wire logic                    regRead,
  output logic      [31:0]             regRdData,
  // Counter control pins
  input  wire logic [1:0]              modeSel,
  input  wire logic                    chainCountEnable_n,
  input  wire logic                    outputEnable_n,
  output logic                         finalValueFlag_n,
  // Shared data pins
  input  wire logic [WIDTH-1:0]        dataIn,
  output logic      [WIDTH-1:0]        dataOut,
  output logic                         dataOe,
  // Interrupt
  output logic                         irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Mode decoding

  function automatic bidc_pkg::bidc_op_t opOf(input logic [1:0] code);
    bidc_pkg::bidc_op_t r;
    r = bidc_pkg::OP_HOLD;
    if (code == MODE_HOLD)
      r = bidc_pkg::OP_HOLD;
    else if (code == MODE_UP)
      r = bidc_pkg::OP_UP;
    else if (code == MODE_DOWN)
      r = bidc_pkg::OP_DOWN;
    else if (code == MODE_LOAD)
      r = bidc_pkg::OP_LOAD;
    return r;
  endfunction

  localparam logic [WIDTH-1:0] ONE = WIDTH'(1);

  logic [WIDTH-1:0]           countReg;
  logic [WIDTH-1:0]           countNext;
  logic                       flagReg;
  logic                       oeReg;
  logic                       ctrlRunReg;
  logic [`BIDC_EVT_W-1:0]     statusReg;
  logic [`BIDC_EVT_W-1:0]     statusNext;
  logic [`BIDC_EVT_W-1:0]     maskReg;
  logic                       irqReg;
  logic [31:0]                rdDataReg;

  wire bidc_pkg::bidc_op_t    op;
  wire                        countEnable;
  wire                        termNext;
  wire                        flagNext;
  wire [WIDTH-1:0]            countUp;
  wire [WIDTH-1:0]            countDown;

  assign op          = opOf(modeSel);
  // Pin enable is the cascade input; software run bit can also freeze
  assign countEnable = !chainCountEnable_n && ctrlRunReg;
  assign countUp     = countReg + ONE;
  assign countDown   = countReg - ONE;

  ////////////////////////////////////////////////////////////////////////////
  // Counter core

  always_comb begin
    countNext = countReg;
    if (countEnable) begin
      unique case (op)
        bidc_pkg::OP_HOLD: countNext = countReg;
        bidc_pkg::OP_UP:   countNext = countUp;
        bidc_pkg::OP_DOWN: countNext = countDown;
        bidc_pkg::OP_LOAD: countNext = dataIn;
      endcase
    end
  end

  // Only clocked updates; nothing else touches the count
  always_ff @(posedge clk_sys) begin
    if (rst)
      countReg <= `BIDC_RST_COUNT;
    else
      countReg <= countNext;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Terminal count look-ahead

  // Decoded from the next count so the registered flag matches
  // the end value as soon as the counter sits on it
  bidc_tc_decode #(
    .WIDTH (WIDTH)
  ) u_tc (
    .value    (countNext),
    .op       (op),
    .enable   (countEnable),
    .terminal (termNext)
  );

  assign flagNext = !termNext;

  // Registered, hence free of decode spikes for the next stage
  always_ff @(posedge clk_sys) begin
    if (rst)
      flagReg <= `BIDC_RST_FLAG;
    else
      flagReg <= flagNext;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data pin drivers

  always_ff @(posedge clk_sys) begin
    if (rst)
      oeReg <= `BIDC_RST_OE;
    else
      oeReg <= !outputEnable_n;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers and interrupt

  wire                    selCtrl;
  wire                    selCount;
  wire                    selStatus;
  wire                    selMask;
  wire [`BIDC_EVT_W-1:0]  events;
  wire [`BIDC_EVT_W-1:0]  clearBits;
  wire [`BIDC_EVT_W-1:0]  maskNext;
  wire [31:0]             rdMux;

  assign selCtrl   = regAddr == `BIDC_OFF_CTRL;
  assign selCount  = regAddr == `BIDC_OFF_COUNT;
  assign selStatus = regAddr == `BIDC_OFF_STATUS;
  assign selMask   = regAddr == `BIDC_OFF_MASK;

  assign events[`BIDC_EVT_TC]   = flagReg && !flagNext;
  assign events[`BIDC_EVT_LOAD] = countEnable && op == bidc_pkg::OP_LOAD;

  assign clearBits  = (regWrite && selStatus) ? regWrData[`BIDC_EVT_W-1:0]
                                              : `BIDC_RST_STATUS;
  // New event beats a clear in the same cycle
  assign statusNext = (statusReg & ~clearBits) | events;
  // Interrupt uses the next mask too, so it never lags a mask write
  assign maskNext   = (regWrite && selMask) ? regWrData[`BIDC_EVT_W-1:0] : maskReg;

  assign rdMux = selCtrl   ? {31'h0000_0000, ctrlRunReg} :
                 selCount  ? {22'h00_0000, oeReg, flagReg, countReg} :
                 selStatus ? {30'h0000_0000, statusReg} :
                 selMask   ? {30'h0000_0000, maskReg} :
                             32'h0000_0000;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ctrlRunReg <= `BIDC_RST_CTRL;
      maskReg    <= `BIDC_RST_MASK;
    end else begin
      if (regWrite && selCtrl)
        ctrlRunReg <= regWrData[`BIDC_CTRL_RUN];
      maskReg <= maskNext;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      statusReg <= `BIDC_RST_STATUS;
      irqReg    <= 1'h0;
      rdDataReg <= 32'h0000_0000;
    end else begin
      statusReg <= statusNext;
      irqReg    <= |(statusNext & maskNext);
      rdDataReg <= regRead ? rdMux : 32'h0000_0000;
    end
  end

  assign regRdData        = rdDataReg;
  assign finalValueFlag_n = flagReg;
  assign dataOut          = countReg;
  assign dataOe           = oeReg;
  assign irq              = irqReg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  a_count_up_step:     assert property (
    countEnable && op == bidc_pkg::OP_UP |=> countReg == $past(countUp))
    else $error("count up did not add one");

  a_count_down_step:   assert property (
    countEnable && op == bidc_pkg::OP_DOWN |=> countReg == $past(countDown))
    else $error("count down did not subtract one");

  a_load_takes_pins:   assert property (
    countEnable && op == bidc_pkg::OP_LOAD |=> countReg == $past(dataIn))
    else $error("load did not take data pins");

  a_change_has_cause:  assert property (
    !$past(rst) && countReg != $past(countReg)
      |-> $past(countEnable) && $past(op) != bidc_pkg::OP_HOLD)
    else $error("count changed without an enabled operation");

  a_disable_freezes:   assert property (
    chainCountEnable_n |=> $stable(countReg) && finalValueFlag_n)
    else $error("disabled counter moved or flagged");

  a_flag_lookahead:    assert property (
    countEnable && op == bidc_pkg::OP_UP && countReg == {WIDTH{1'b1}} - ONE
      |=> !finalValueFlag_n ##1 (finalValueFlag_n || countReg == {WIDTH{1'b1}}))
    else $error("terminal flag missed the end value");

  a_flag_only_at_end:  assert property (
    !finalValueFlag_n |-> $past(countEnable) &&
      ((countReg == {WIDTH{1'b1}} && $past(op) == bidc_pkg::OP_UP) ||
       (countReg == {WIDTH{1'b0}} && $past(op) == bidc_pkg::OP_DOWN)))
    else $error("terminal flag away from end value");

  a_pins_driven:       assert property (
    !outputEnable_n |=> dataOe && dataOut == countReg)
    else $error("pins not driven while enabled");

  a_pins_float:        assert property (
    outputEnable_n [*2] |-> ##1 !dataOe)
    else $error("pins driven while disabled");

  a_irq_from_status:   assert property (
    $rose(statusReg[`BIDC_EVT_TC]) && maskReg[`BIDC_EVT_TC] |-> irq)
    else $error("masked-in event gave no interrupt");

  a_irq_level:         assert property (
    irq == |(statusReg & maskReg))
    else $error("interrupt does not match unmasked status");

endmodule
`default_nettype wire

// ==== design/bidc_tc_decode.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "bidc_defs.svh"

module bidc_tc_decode #(
  parameter int WIDTH = `BIDC_WIDTH
) (
  // Operand
  input  wire logic [WIDTH-1:0]      value,
  input  wire bidc_pkg::bidc_op_t    op,
  input  wire logic                  enable,
  // Result
  output logic                       terminal
);

  wire atTop;
  wire atBottom;

  assign atTop    = &value;
  assign atBottom = ~|value;

  // End value depends on direction; hold and load never flag
  assign terminal = enable &&
                    ((op == bidc_pkg::OP_UP   && atTop) ||
                     (op == bidc_pkg::OP_DOWN && atBottom));

endmodule
`default_nettype wire

// ==== sim/bidc_bus_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module bidc_bus_model (
  // Clock
  input  wire logic       clk_sys,
  // Device side of the pins
  input  wire logic [7:0] dataOut,
  input  wire logic       dataOe,
  // Other talker on the bus
  input  wire logic       busDrive,
  input  wire logic [7:0] busValue,
  // Level on the pins
  output logic      [7:0] pinLevel
);
  logic [7:0] lastLevel = 8'h00;
  // No pull on the bus: a floating bus shows a changing pattern, never a stale value
  assign pinLevel = dataOe ? dataOut : (busDrive ? busValue : ~lastLevel);
  always @(posedge clk_sys) lastLevel <= pinLevel;
endmodule
`default_nettype wire

// ==== sim/testbench.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "bidc_defs.svh"
module testbench;
  logic clk_sys = 1'b0, rst = 1'b1, live = 1'b0;
  logic [3:0] regAddr = 4'h0;
  logic [31:0] regWrData = 32'h0000_0000, regRdData;
  logic regWrite = 1'b0, regRead = 1'b0;
  logic [1:0] modeSel = `BIDC_MODE_HOLD;
  logic chainCountEnable_n = 1'b1, outputEnable_n = 1'b1, busDrive = 1'b0;
  logic [7:0] busValue = 8'h00, dataIn, dataOut, expCount, nxt;
  logic finalValueFlag_n, dataOe, irq, expFlag_n, expOe, expRun, en;
  int fails = 0, comparisons = 0, cycles = 0, seed = 39599, r;
  bidc_counter uut (.clk_sys(clk_sys), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .modeSel(modeSel),
    .chainCountEnable_n(chainCountEnable_n), .outputEnable_n(outputEnable_n),
    .finalValueFlag_n(finalValueFlag_n), .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe), .irq(irq));
  bidc_bus_model bus (.clk_sys(clk_sys), .dataOut(dataOut), .dataOe(dataOe), .busDrive(busDrive),
    .busValue(busValue), .pinLevel(dataIn));
  initial forever #25 clk_sys = ~clk_sys;
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic print_verdict;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge clk_sys);
    regWrite <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input string what, input logic [3:0] a, input logic [31:0] exp);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk_sys);
    regRead <= 1'b0;
    @(negedge clk_sys);
    check(what, exp, regRdData);
    @(posedge clk_sys);
  endtask
  task automatic pins(input logic [1:0] m, input logic c, o, d, input logic [7:0] v, input int n);
    modeSel <= m;
    chainCountEnable_n <= c;
    outputEnable_n <= o;
    busDrive <= d;
    busValue <= v;
    repeat (n) @(posedge clk_sys);
  endtask
  // Expected count after one edge
  function automatic logic [7:0] expNext(input logic [1:0] m, input logic e,
                                         input logic [7:0] c, input logic [7:0] d);
    logic [7:0] n;
    n = c;
    if (e) begin
      case (m)
        `BIDC_MODE_UP:   n = c + 8'h01;
        `BIDC_MODE_DOWN: n = c - 8'h01;
        `BIDC_MODE_LOAD: n = d;
        default:         n = c;
      endcase
    end
    return n;
  endfunction
  // Expected flag: low only after an enabled step onto the end value
  function automatic logic expFlag(input logic [1:0] m, input logic e, input logic [7:0] n);
    return !(e && ((m == `BIDC_MODE_UP && n == 8'hFF) || (m == `BIDC_MODE_DOWN && n == 8'h00)));
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  // Ceiling far above the few thousand cycles the tests need
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      print_verdict();
    end
  end
  // Reference: flag only sampled here, never used as a clock
  always @(posedge clk_sys) begin
    en = !chainCountEnable_n && expRun;
    nxt = expNext(modeSel, en, expCount, dataIn);
    if (rst) begin
      expCount <= 8'h00;
      expFlag_n <= 1'b1;
      expOe <= 1'b0;
      expRun <= 1'b1;
    end else begin
      expCount <= nxt;
      expFlag_n <= expFlag(modeSel, en, nxt);
      expOe <= !outputEnable_n;
      if (regWrite && regAddr == `BIDC_OFF_CTRL) expRun <= regWrData[0];
    end
  end
  always @(negedge clk_sys) begin
    if (live && !rst) begin
      check("count", expCount, dataOut);
      check("flag", expFlag_n, finalValueFlag_n);
      check("oe", expOe, dataOe);
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    live <= 1'b1;
    @(posedge clk_sys);
    rd("ctrl", `BIDC_OFF_CTRL, 32'h0000_0001);
    rd("status", `BIDC_OFF_STATUS, 32'h0000_0000);
    rd("mask", `BIDC_OFF_MASK, 32'h0000_0000);
    rd("unmapped", 4'h2, 32'h0000_0000);
    wr(`BIDC_OFF_COUNT, 32'h0000_00FF);
    rd("count reg", `BIDC_OFF_COUNT, 32'h0000_0100);
    $display("test registers done");
    wr(`BIDC_OFF_MASK, 32'h0000_0001);
    pins(`BIDC_MODE_LOAD, 1'b0, 1'b1, 1'b1, 8'hFE, 1);
    pins(`BIDC_MODE_UP, 1'b0, 1'b1, 1'b0, 8'h00, 2);
    pins(`BIDC_MODE_HOLD, 1'b1, 1'b1, 1'b0, 8'h00, 3);
    check("irq set", 1'b1, irq);
    rd("status set", `BIDC_OFF_STATUS, 32'h0000_0003);
    wr(`BIDC_OFF_STATUS, 32'h0000_0001);
    pins(`BIDC_MODE_HOLD, 1'b1, 1'b1, 1'b0, 8'h00, 2);
    check("irq clear", 1'b0, irq);
    rd("status clear", `BIDC_OFF_STATUS, 32'h0000_0002);
    wr(`BIDC_OFF_MASK, 32'h0000_0003);
    @(posedge clk_sys);
    check("irq unmask", 1'b1, irq);
    wr(`BIDC_OFF_MASK, 32'h0000_0000);
    pins(`BIDC_MODE_LOAD, 1'b0, 1'b1, 1'b1, 8'h01, 1);
    pins(`BIDC_MODE_DOWN, 1'b0, 1'b1, 1'b0, 8'h00, 3);
    check("irq masked", 1'b0, irq);
    $display("test terminal count done");
    wr(`BIDC_OFF_CTRL, 32'h0000_0000);
    pins(`BIDC_MODE_UP, 1'b0, 1'b0, 1'b0, 8'h00, 4);
    wr(`BIDC_OFF_CTRL, 32'h0000_0001);
    $display("test run gate done");
    repeat (2000) begin
      r = $random(seed);
      pins(r[1:0], r[4:2] == 3'h0, r[5], r[6], r[15:8], 1);
    end
    $display("test random done");
    // Mid-run reset must restore control and mask
    wr(`BIDC_OFF_CTRL, 32'h0000_0000);
    pins(`BIDC_MODE_HOLD, 1'b1, 1'b1, 1'b0, 8'h00, 1);
    wr(`BIDC_OFF_MASK, 32'h0000_0003);
    rst <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    check("irq after reset", 1'b0, irq);
    rd("ctrl after reset", `BIDC_OFF_CTRL, 32'h0000_0001);
    rd("mask after reset", `BIDC_OFF_MASK, 32'h0000_0000);
    rd("count after reset", `BIDC_OFF_COUNT, 32'h0000_0100);
    $display("test mid-run reset done");
    print_verdict();
  end
endmodule
`default_nettype wire
